/* design/pea_energy_acc.sv */
// power and energy accumulator with its register slave
module pea_energy_acc
    import pea_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // converter samples, same clock
    input wire logic sample_valid_i,
    input wire logic [SAMPLE_W-1:0] bus_sample_i,
    input wire logic [SAMPLE_W-1:0] shunt_sample_i,
    // slow pin, asynchronous
    input wire logic slow_pin_i,
    // fullness alerts
    output logic fullness_threshold_o,
    output logic count_full_o,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // left shift that maps a rate code onto 8192 sps
    function automatic logic [3:0] rate_shift(input logic [2:0] code);
        case (code)
            3'h0: rate_shift = 4'hA;
            3'h1: rate_shift = 4'h7;
            3'h2: rate_shift = 4'h5;
            3'h3: rate_shift = 4'h3;
            3'h4: rate_shift = 4'h1;
            default: rate_shift = 4'h0;
        endcase
    endfunction

    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [10:0] control_reg;
    logic [3:0] range_reg;
    logic [3:0] slow_cfg_reg;
    logic [ACC_W-1:0] base_reg;
    logic [5:0] thresh_reg;
    logic [1:0] count_lim_reg;
    logic [ACC_W-1:0] energy_accumulator;
    logic [COUNT_W-1:0] sample_counter;
    logic acc_sat_reg;
    logic cnt_sat_reg;
    logic [ACC_W-1:0] acc_snap_reg;
    logic [COUNT_W-1:0] cnt_snap_reg;
    logic [SAMPLE_W-1:0] bus_res_reg;
    logic [SAMPLE_W-1:0] shunt_res_reg;
    logic [PRODUCT_W-1:0] power_res_reg;
    logic cap_valid_reg;
    logic [SAMPLE_W-1:0] cap_bus_reg;
    logic [SAMPLE_W-1:0] cap_shunt_reg;
    logic slow_s1_reg;
    logic slow_s2_reg;
    logic slow_s3_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;

    // ------------------------------------------------------------
    // capture and multiply
    // ------------------------------------------------------------
    logic mul_valid;
    logic signed [SAMPLE_W-1:0] mul_bus;
    logic signed [SAMPLE_W-1:0] mul_shunt;
    logic signed [PRODUCT_W-1:0] power_product;

    // first stage holds the digitized pair
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cap_valid_reg <= 1'b0;
            cap_bus_reg <= '0;
            cap_shunt_reg <= '0;
        end else begin
            cap_valid_reg <= sample_valid_i;
            if (sample_valid_i) begin
                cap_bus_reg <= bus_sample_i;
                cap_shunt_reg <= shunt_sample_i;
            end
        end
    end

    pea_mult u_mult (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(cap_valid_reg),
        .bus_i(cap_bus_reg),
        .shunt_i(cap_shunt_reg),
        .out_valid_o(mul_valid),
        .bus_o(mul_bus),
        .shunt_o(mul_shunt),
        .product_o(power_product)
    );

    // ------------------------------------------------------------
    // slow pin synchroniser and refresh requests
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            slow_s1_reg <= 1'b0;
            slow_s2_reg <= 1'b0;
            slow_s3_reg <= 1'b0;
        end else begin
            slow_s1_reg <= slow_pin_i;
            slow_s2_reg <= slow_s1_reg;
            slow_s3_reg <= slow_s2_reg;
        end
    end

    logic slow_rise;
    logic slow_fall;
    logic wr_fire;
    logic wr_refresh;
    logic refresh_full;
    logic refresh_value;
    assign slow_rise = slow_s2_reg & ~slow_s3_reg;
    assign slow_fall = ~slow_s2_reg & slow_s3_reg;
    assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign wr_refresh = wr_fire && (awaddr_reg == OFS_REFRESH) && wstrb_reg[0];
    // full and global refresh reload the base and clear the count, value refresh only snapshots
    assign refresh_full = (wr_refresh && (wdata_reg[REF_FULL_BIT] || wdata_reg[REF_GLOBAL_BIT]))
        || (slow_rise && slow_cfg_reg[SLW_RISE_FULL_BIT])
        || (slow_fall && slow_cfg_reg[SLW_FALL_FULL_BIT]);
    assign refresh_value = (wr_refresh && wdata_reg[REF_VALUE_BIT])
        || (slow_rise && slow_cfg_reg[SLW_RISE_VALUE_BIT])
        || (slow_fall && slow_cfg_reg[SLW_FALL_VALUE_BIT]);

    // ------------------------------------------------------------
    // accumulate source, scaling and saturation
    // ------------------------------------------------------------
    logic adapt_on;
    logic [2:0] eff_rate;
    logic [3:0] shift;
    logic [ACC_W-1:0] addend;
    logic [ACC_W:0] acc_sum;
    logic acc_ovf;
    logic [COUNT_W:0] cnt_sum;

    assign adapt_on = control_reg[CTL_ADAPT_BIT];
    assign eff_rate = slow_s2_reg ? control_reg[CTL_SLOW_RATE_LSB +: 3]
                                  : control_reg[CTL_RATE_LSB +: 3];
    assign shift = (adapt_on && eff_rate < RATE_MAX) ? rate_shift(eff_rate) : 4'h0;

    // pick source and sign-extend to accumulator width
    always_comb begin
        case (pea_src_t'(control_reg[CTL_SRC_LSB +: 2]))
            PEA_SRC_SHUNT: addend = {{(ACC_W-SAMPLE_W){mul_shunt[SAMPLE_W-1]}}, mul_shunt};
            PEA_SRC_BUS: addend = {{(ACC_W-SAMPLE_W){mul_bus[SAMPLE_W-1]}}, mul_bus};
            default: addend = {{(ACC_W-PRODUCT_W){power_product[PRODUCT_W-1]}},
                               power_product};
        endcase
        addend = addend << shift;
    end

    assign acc_sum = {energy_accumulator[ACC_W-1], energy_accumulator}
        + {addend[ACC_W-1], addend};
    assign acc_ovf = acc_sum[ACC_W] != acc_sum[ACC_W-1];
    assign cnt_sum = {1'b0, sample_counter} + ((COUNT_W+1)'(1) << shift);

    // energy accumulator
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            energy_accumulator <= '0;
            acc_sat_reg <= 1'b0;
        end else if (refresh_full) begin
            energy_accumulator <= base_reg;
            acc_sat_reg <= 1'b0;
        end else if (mul_valid && !acc_sat_reg) begin
            if (acc_ovf) begin
                // clamp to the extreme of the overflow direction
                energy_accumulator <= {acc_sum[ACC_W], {(ACC_W-1){~acc_sum[ACC_W]}}};
                acc_sat_reg <= 1'b1;
            end else begin
                energy_accumulator <= acc_sum[ACC_W-1:0];
            end
        end
    end

    // sample counter
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sample_counter <= '0;
            cnt_sat_reg <= 1'b0;
        end else if (refresh_full) begin
            sample_counter <= '0;
            cnt_sat_reg <= 1'b0;
        end else if (mul_valid && !cnt_sat_reg) begin
            if (cnt_sum[COUNT_W]) begin
                sample_counter <= '1;
                cnt_sat_reg <= 1'b1;
            end else begin
                sample_counter <= cnt_sum[COUNT_W-1:0];
                cnt_sat_reg <= &cnt_sum[COUNT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // fullness comparison
    // ------------------------------------------------------------
    logic [COUNT_W-1:0] cnt_limit;
    always_comb begin
        case (count_lim_reg)
            2'h1: cnt_limit = 32'hC000_0000;
            2'h2: cnt_limit = 32'hE000_0000;
            2'h3: cnt_limit = 32'hF000_0000;
            default: cnt_limit = 32'hFFFF_FFFF;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            fullness_threshold_o <= 1'b0;
            count_full_o <= 1'b0;
        end else begin
            fullness_threshold_o <= energy_accumulator[ACC_W-1 -: 6] > thresh_reg;
            count_full_o <= sample_counter >= cnt_limit;
        end
    end

    // ------------------------------------------------------------
    // readable snapshots
    // ------------------------------------------------------------
    logic uni;
    assign uni = (range_reg[RNG_BUS_LSB +: 2] == PEA_RNG_UNIPOLAR)
        && (range_reg[RNG_SENSE_LSB +: 2] == PEA_RNG_UNIPOLAR);

    // any refresh copies live state; negative bus and shunt results clamp to zero when both ranges are unipolar
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            acc_snap_reg <= '0;
            cnt_snap_reg <= '0;
            bus_res_reg <= '0;
            shunt_res_reg <= '0;
            power_res_reg <= '0;
        end else if (refresh_full || refresh_value) begin
            acc_snap_reg <= energy_accumulator;
            cnt_snap_reg <= sample_counter;
            power_res_reg <= power_product;
            // half range codes keep raw samples, only the lsb weight differs
            if (uni) begin
                bus_res_reg <= mul_bus[SAMPLE_W-1] ? '0 : mul_bus;
                shunt_res_reg <= mul_shunt[SAMPLE_W-1] ? '0 : mul_shunt;
            end else begin
                bus_res_reg <= mul_bus;
                shunt_res_reg <= mul_shunt;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;

    logic wr_mapped;
    assign wr_mapped = awaddr_reg == OFS_CONTROL || awaddr_reg == OFS_RANGE_CFG
        || awaddr_reg == OFS_SLOW_CFG || awaddr_reg == OFS_REFRESH
        || awaddr_reg == OFS_BASE_LO || awaddr_reg == OFS_BASE_HI
        || awaddr_reg == OFS_FULL_LIMIT;

    // address and data held until both present
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            control_reg <= CONTROL_RST;
            range_reg <= RANGE_RST;
            slow_cfg_reg <= SLOW_CFG_RST;
            base_reg <= BASE_RST;
            thresh_reg <= THRESH_RST;
            count_lim_reg <= COUNT_LIM_RST;
        end else if (wr_fire) begin
            case (awaddr_reg)
                OFS_CONTROL: control_reg <= 11'(merge(32'(control_reg), wdata_reg, wstrb_reg));
                OFS_RANGE_CFG: range_reg <= 4'(merge(32'(range_reg), wdata_reg, wstrb_reg));
                OFS_SLOW_CFG: slow_cfg_reg <= 4'(merge(32'(slow_cfg_reg), wdata_reg, wstrb_reg));
                OFS_BASE_LO: base_reg[31:0] <= merge(base_reg[31:0], wdata_reg, wstrb_reg);
                OFS_BASE_HI: base_reg[ACC_W-1:32] <=
                    (ACC_W-32)'(merge(32'(base_reg[ACC_W-1:32]), wdata_reg, wstrb_reg));
                OFS_FULL_LIMIT: begin
                    if (wstrb_reg[0]) begin
                        thresh_reg <= wdata_reg[5:0];
                    end
                    if (wstrb_reg[1]) begin
                        count_lim_reg <= wdata_reg[LIM_COUNT_LSB +: 2];
                    end
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;

    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
            OFS_CONTROL: rd_word = 32'(control_reg);
            OFS_RANGE_CFG: rd_word = 32'(range_reg);
            OFS_SLOW_CFG: rd_word = 32'(slow_cfg_reg);
            OFS_REFRESH: rd_word = 32'h0000_0000;
            OFS_BASE_LO: rd_word = base_reg[31:0];
            OFS_BASE_HI: rd_word = 32'(base_reg[ACC_W-1:32]);
            OFS_FULL_LIMIT: rd_word = {22'h00_0000, count_lim_reg, 2'h0, thresh_reg};
            OFS_ACC_LO: rd_word = acc_snap_reg[31:0];
            OFS_ACC_HI: rd_word = 32'(acc_snap_reg[ACC_W-1:32]);
            OFS_COUNT: rd_word = cnt_snap_reg;
            OFS_BUS_RES: rd_word = 32'(bus_res_reg);
            OFS_SHUNT_RES: rd_word = 32'(shunt_res_reg);
            OFS_POWER_RES: rd_word = 32'(power_res_reg);
            OFS_STATUS: rd_word = {27'h000_0000, slow_s2_reg, cnt_sat_reg, acc_sat_reg,
                                   count_full_o, fullness_threshold_o};
            default: begin
                rd_word = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // pea_energy_acc

/* design/pea_mult.sv */
// registered signed multiplier stage of the accumulator datapath
module pea_mult
    import pea_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // captured samples
    input wire logic in_valid_i,
    input wire logic signed [SAMPLE_W-1:0] bus_i,
    input wire logic signed [SAMPLE_W-1:0] shunt_i,
    // product stage
    output logic out_valid_o,
    output logic signed [SAMPLE_W-1:0] bus_o,
    output logic signed [SAMPLE_W-1:0] shunt_o,
    output logic signed [PRODUCT_W-1:0] product_o
);

    // ------------------------------------------------------------
    // product register
    // ------------------------------------------------------------
    // two's complement product of the raw samples
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            bus_o <= '0;
            shunt_o <= '0;
            product_o <= '0;
        end else begin
            out_valid_o <= in_valid_i;
            if (in_valid_i) begin
                bus_o <= bus_i;
                shunt_o <= shunt_i;
                product_o <= bus_i * shunt_i;
            end
        end
    end

endmodule // pea_mult

/* design/pea_pkg.sv */
// constants and register map of the power and energy accumulator
package pea_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int SAMPLE_W = 12;
    localparam int PRODUCT_W = 24;
    localparam int ACC_W = 56;
    localparam int COUNT_W = 32;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_RANGE_CFG = 8'h04;
    localparam logic [7:0] OFS_SLOW_CFG = 8'h08;
    localparam logic [7:0] OFS_REFRESH = 8'h0C;
    localparam logic [7:0] OFS_BASE_LO = 8'h10;
    localparam logic [7:0] OFS_BASE_HI = 8'h14;
    localparam logic [7:0] OFS_FULL_LIMIT = 8'h18;
    localparam logic [7:0] OFS_ACC_LO = 8'h1C;
    localparam logic [7:0] OFS_ACC_HI = 8'h20;
    localparam logic [7:0] OFS_COUNT = 8'h24;
    localparam logic [7:0] OFS_BUS_RES = 8'h28;
    localparam logic [7:0] OFS_SHUNT_RES = 8'h2C;
    localparam logic [7:0] OFS_POWER_RES = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_ADAPT_BIT = 0;
    localparam int CTL_SRC_LSB = 1;
    localparam int CTL_RATE_LSB = 4;
    localparam int CTL_SLOW_RATE_LSB = 8;
    localparam int RNG_BUS_LSB = 0;
    localparam int RNG_SENSE_LSB = 2;
    localparam int REF_FULL_BIT = 0;
    localparam int REF_VALUE_BIT = 1;
    localparam int REF_GLOBAL_BIT = 2;
    localparam int SLW_RISE_FULL_BIT = 0;
    localparam int SLW_FALL_FULL_BIT = 1;
    localparam int SLW_RISE_VALUE_BIT = 2;
    localparam int SLW_FALL_VALUE_BIT = 3;
    localparam int LIM_COUNT_LSB = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [10:0] CONTROL_RST = 11'h030;
    localparam logic [3:0] RANGE_RST = 4'h0;
    localparam logic [3:0] SLOW_CFG_RST = 4'h0;
    localparam logic [ACC_W-1:0] BASE_RST = 56'h00_0000_0000_0000;
    localparam logic [5:0] THRESH_RST = 6'h3F;
    localparam logic [1:0] COUNT_LIM_RST = 2'h0;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PEA_SRC_POWER = 2'b00,
        PEA_SRC_SHUNT = 2'b01,
        PEA_SRC_BUS = 2'b10,
        PEA_SRC_POWER2 = 2'b11
    } pea_src_t;

    typedef enum logic [1:0] {
        PEA_RNG_UNIPOLAR = 2'b00,
        PEA_RNG_BIPOLAR = 2'b01,
        PEA_RNG_HALF = 2'b10,
        PEA_RNG_RSVD = 2'b11
    } pea_range_t;

    // rate codes: 0=8 1=64 2=256 3=1024 4=4096 5=8192 sps
    localparam logic [2:0] RATE_MAX = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : pea_pkg

/* test/pea_energy_acc_asserts.sv */
// bus handshake and fullness flag checks for the energy accumulator
module pea_energy_acc_asserts
    import pea_pkg::*;
(
    input logic clk_sys_i,
    input logic rst_n_i,
    input logic sample_valid_i,
    input logic fullness_threshold_o,
    input logic count_full_o,
    input logic [ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] quiet_cnt;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    // cycles since the last sample or register write
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || sample_valid_i || (s_axi_wvalid && s_axi_wready)) begin
            quiet_cnt <= 4'h0;
        end else if (quiet_cnt != 4'hF) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
    end
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("aw or w open");
    unmapped_write_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && s_axi_awaddr >= OFS_ACC_LO |-> ##[1:2] s_axi_bvalid
        && s_axi_bresp == RESP_SLVERR) else $error("unmapped write accepted");
    flag_cause_a: assert property ($changed(fullness_threshold_o) || $changed(count_full_o)
        |-> quiet_cnt <= 4'h6) else $error("flag moved without cause");
endmodule // pea_energy_acc_asserts

bind pea_energy_acc pea_energy_acc_asserts u_chk (.*);

/* test/pea_energy_acc_test.sv */
// self-checking bench for the energy accumulator
module pea_energy_acc_test
    import pea_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i, rst_n_i, sample_valid_i, slow_pin_i, fullness_threshold_o, count_full_o;
    logic [SAMPLE_W-1:0] bus_sample_i, shunt_sample_i;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_errors = 0;
    int checked = 0;
    logic [31:0] ctl_tab [5] = '{32'h30, 32'h32, 32'h34, 32'h36, 32'h35};
    logic [31:0] acc_tab [5] = '{32'hFFFFFFF1, 32'hFFFFFFFD, 32'h5, 32'hFFFFFFF1, 32'h28};
    // design and converter model
    pea_energy_acc dut (.*);
    pea_sample_src src (.clk_sys_i(clk_sys_i), .valid_o(sample_valid_i),
        .bus_o(bus_sample_i), .shunt_o(shunt_sample_i));
    // 200 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // counts and verdict
    task automatic summarize();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one write, response code compared
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        chk(32'(n < 50), 32'h1);
        if (n >= 50) summarize();
    endtask
    // one read, data and response compared
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        chk(32'(n < 50), 32'h1);
        if (n >= 50) summarize();
    endtask
    // main sequence
    initial begin
        rst_n_i = 1'b0;
        slow_pin_i = 1'b0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(OFS_CONTROL, {21'h0, CONTROL_RST}, RESP_OKAY);
        rd(OFS_FULL_LIMIT, 32'h3F, RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(OFS_ACC_LO, 32'h1, RESP_SLVERR);
        // every source, then adaptive scaling at 1024 sps
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CONTROL, ctl_tab[i], RESP_OKAY);
            wr(OFS_REFRESH, 32'h1, RESP_OKAY);
            src.send(12'h005, 12'hFFD);
            wr(OFS_REFRESH, 32'h2, RESP_OKAY);
            rd(OFS_ACC_LO, acc_tab[i], RESP_OKAY);
            rd(OFS_ACC_HI, acc_tab[i][31] ? 32'hFFFFFF : 32'h0, RESP_OKAY);
            rd(OFS_POWER_RES, 32'hFFFFF1, RESP_OKAY);
            rd(OFS_COUNT, (i == 4) ? 32'h8 : 32'h1, RESP_OKAY);
            rd(OFS_SHUNT_RES, 32'h0, RESP_OKAY);
        end
        // start from the base value at the positive limit
        wr(OFS_CONTROL, 32'h30, RESP_OKAY);
        // source changed, value refresh keeps the sum; bipolar and half ranges show raw
        wr(OFS_RANGE_CFG, 32'h9, RESP_OKAY);
        wr(OFS_REFRESH, 32'h2, RESP_OKAY);
        rd(OFS_ACC_LO, 32'h28, RESP_OKAY);
        rd(OFS_SHUNT_RES, 32'hFFD, RESP_OKAY);
        rd(OFS_BUS_RES, 32'h5, RESP_OKAY);
        wr(OFS_BASE_LO, 32'hFFFFFFFF, RESP_OKAY);
        wr(OFS_BASE_HI, 32'h7FFFFF, RESP_OKAY);
        wr(OFS_REFRESH, 32'h1, RESP_OKAY);
        src.send(12'h001, 12'h001);
        wr(OFS_REFRESH, 32'h2, RESP_OKAY);
        rd(OFS_ACC_LO, 32'hFFFFFFFF, RESP_OKAY);
        rd(OFS_ACC_HI, 32'h7FFFFF, RESP_OKAY);
        rd(OFS_COUNT, 32'h1, RESP_OKAY);
        // top six bits are 0x1F: threshold just below, then equal
        wr(OFS_FULL_LIMIT, 32'h1E, RESP_OKAY);
        repeat (3) @(posedge clk_sys_i);
        chk({30'h0, fullness_threshold_o, count_full_o}, 32'h2);
        wr(OFS_FULL_LIMIT, 32'h31F, RESP_OKAY);
        repeat (3) @(posedge clk_sys_i);
        chk({30'h0, fullness_threshold_o, count_full_o}, 32'h0);
        // slow pin rise set to issue a full refresh: count clears, base reloads
        wr(OFS_SLOW_CFG, 32'h1, RESP_OKAY);
        slow_pin_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        wr(OFS_REFRESH, 32'h2, RESP_OKAY);
        rd(OFS_COUNT, 32'h0, RESP_OKAY);
        rd(OFS_ACC_HI, 32'h7FFFFF, RESP_OKAY);
        summarize();
    end
endmodule // pea_energy_acc_test

/* test/pea_sample_src.sv */
// converter model: one sample per call, scrambled lines when idle
module pea_sample_src
    import pea_pkg::*;
(
    input logic clk_sys_i,
    output logic valid_o,
    output logic [SAMPLE_W-1:0] bus_o,
    output logic [SAMPLE_W-1:0] shunt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle lines at time zero
    initial begin
        valid_o = 1'b0;
        bus_o = '0;
        shunt_o = '0;
    end
    // one sample, then inverted lines while the pipeline settles
    task automatic send(input logic [SAMPLE_W-1:0] b, input logic [SAMPLE_W-1:0] s);
        @(posedge clk_sys_i);
        valid_o <= 1'b1;
        bus_o <= b;
        shunt_o <= s;
        @(posedge clk_sys_i);
        valid_o <= 1'b0;
        bus_o <= ~b;
        shunt_o <= ~s;
        repeat (5) @(posedge clk_sys_i);
    endtask
endmodule // pea_sample_src
